// ==== logic/umm_core.v ====
// mode register decode, channel test-mode routing and interrupt masking
`timescale 1ns/10ps
`include "umm_map.vh"

module umm_core (
  // clock and reset
  input wire sys_clk_i,
  input wire arst_n_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [31:0] reg_rdata_o,
  // events from the serial datapath, one-cycle pulses
  input wire [9:0] event_i,
  // interrupt
  output wire irq_o,
  // datapath side of the channel
  input wire tx_serial_i,
  input wire baud_clk_i,
  output wire rx_serial_o,
  output wire tx_enable_o,
  output wire rx_enable_o,
  // decoded configuration
  output wire [2:0] stop_halves_o,
  output wire stop_reserved_o,
  output wire [3:0] char_bits_o,
  output wire sync_mode_o,
  output wire [2:0] parity_type_o,
  output wire [1:0] baud_source_select_o,
  output wire sck_in_o,
  // pins
  input wire rxd_i,
  output wire txd_o,
  input wire sck_i,
  output wire sck_o,
  output wire sck_oe_o
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // stop code to half bit periods; reserved codes give one stop bit
  function [2:0] umm_stop_halves;
    input [1:0] code;
    input sync;
    begin
      case (code)
        `UMM_STOP_ONE: begin
          umm_stop_halves = `UMM_HALVES_ONE;
        end
        `UMM_STOP_ONEHALF: begin
          umm_stop_halves = sync ? `UMM_HALVES_ONE : `UMM_HALVES_ONEHALF;
        end
        `UMM_STOP_TWO: begin
          umm_stop_halves = `UMM_HALVES_TWO;
        end
        default: begin
          umm_stop_halves = `UMM_HALVES_ONE;
        end
      endcase
    end
  endfunction

  // reserved stop codes depend on the timing mode
  function umm_stop_rsvd;
    input [1:0] code;
    input sync;
    begin
      case (code)
        `UMM_STOP_ONE: begin
          umm_stop_rsvd = 1'b0;
        end
        `UMM_STOP_ONEHALF: begin
          umm_stop_rsvd = sync;
        end
        `UMM_STOP_TWO: begin
          umm_stop_rsvd = 1'b0;
        end
        default: begin
          umm_stop_rsvd = 1'b1;
        end
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register state

  reg [31:0] mode_ff;
  reg [31:0] nxt_mode;
  reg [9:0] mask_ff;
  reg [9:0] nxt_mask;
  reg [9:0] stat_ff;
  reg [9:0] nxt_stat;
  reg irq_ff;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;

  wire wr_mode = reg_wr_i && (reg_addr_i == `UMM_OFS_MODE);
  wire wr_set = reg_wr_i && (reg_addr_i == `UMM_OFS_IEN_SET);
  wire wr_clr = reg_wr_i && (reg_addr_i == `UMM_OFS_IEN_CLR);
  wire wr_stat = reg_wr_i && (reg_addr_i == `UMM_OFS_EVT_STAT);

  // mode register, reserved bits never stored so they read as zero
  always @* begin
    nxt_mode = mode_ff;
    if (wr_mode) begin
      nxt_mode = reg_wdata_i & `UMM_MODE_WMASK;
    end
  end

  // mask: set and clear act only on ones; a bit in both writes cannot coexist
  // since a strobe carries one address, so no priority is needed
  always @* begin
    nxt_mask = mask_ff;
    if (wr_set) begin
      nxt_mask = mask_ff | reg_wdata_i[9:0];
    end
    if (wr_clr) begin
      nxt_mask = mask_ff & ~reg_wdata_i[9:0];
    end
  end

  // sticky event latch; a new event beats a write-one clear in the same cycle
  always @* begin
    nxt_stat = stat_ff;
    if (wr_stat) begin
      nxt_stat = stat_ff & ~reg_wdata_i[9:0];
    end
    nxt_stat = nxt_stat | event_i;
  end

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_ff <= `UMM_RST_MODE;
      mask_ff <= `UMM_RST_MASK;
      stat_ff <= `UMM_RST_STAT;
    end else begin
      mode_ff <= nxt_mode;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
    end
  end

  // interrupt follows the stored latch and mask without extra lag
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_stat & nxt_mask);
    end
  end

  // read data stands only in the cycle after the read strobe
  always @* begin
    nxt_rdata = 32'h00000000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `UMM_OFS_MODE: begin
          nxt_rdata = mode_ff;
        end
        `UMM_OFS_IMASK: begin
          nxt_rdata = {22'h000000, mask_ff};
        end
        `UMM_OFS_EVT_STAT: begin
          nxt_rdata = {22'h000000, stat_ff};
        end
        default: begin
          nxt_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // field decode

  wire [1:0] clks_f = mode_ff[`UMM_MODE_CLKS_LO+1:`UMM_MODE_CLKS_LO];
  wire [1:0] char_length_field_f = mode_ff[`UMM_MODE_CHAR_LENGTH_FIELD_LO+1:`UMM_MODE_CHAR_LENGTH_FIELD_LO];
  wire sync_f = mode_ff[`UMM_MODE_SYNC];
  wire [2:0] par_f = mode_ff[`UMM_MODE_PAR_LO+2:`UMM_MODE_PAR_LO];
  wire [1:0] stop_f = mode_ff[`UMM_MODE_STOP_LO+1:`UMM_MODE_STOP_LO];
  wire [1:0] chm_f = mode_ff[`UMM_MODE_CHM_LO+1:`UMM_MODE_CHM_LO];
  wire nine_f = mode_ff[`UMM_MODE_NINE];
  wire ckdrv_f = mode_ff[`UMM_MODE_CKDRV];

  reg [2:0] stop_halves_ff;
  reg stop_rsvd_ff;
  reg [3:0] char_bits_ff;
  reg sync_ff;
  reg [2:0] par_ff;
  reg [1:0] clks_ff;

  // decoded settings registered so every output leaves a flop
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stop_halves_ff <= `UMM_HALVES_ONE;
      stop_rsvd_ff <= 1'b0;
      char_bits_ff <= 4'h5;
      sync_ff <= 1'b0;
      par_ff <= 3'h0;
      clks_ff <= 2'h0;
    end else begin
      stop_halves_ff <= umm_stop_halves(stop_f, sync_f);
      // flag only; a reserved code still decodes to one stop bit
      // reserved code flagged
      stop_rsvd_ff <= umm_stop_rsvd(stop_f, sync_f);
      char_bits_ff <= nine_f ? 4'h9 : ({2'h0, char_length_field_f} + 4'h5);
      sync_ff <= sync_f;
      par_ff <= par_f;
      clks_ff <= clks_f;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins and channel routing

  reg rxd_meta_ff;
  reg rxd_sync_ff;
  reg sck_meta_ff;
  reg sck_sync_ff;

  // two-stage synchronisers for the pin inputs
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxd_meta_ff <= 1'b1;
      rxd_sync_ff <= 1'b1;
      sck_meta_ff <= 1'b0;
      sck_sync_ff <= 1'b0;
    end else begin
      rxd_meta_ff <= rxd_i;
      rxd_sync_ff <= rxd_meta_ff;
      sck_meta_ff <= sck_i;
      sck_sync_ff <= sck_meta_ff;
    end
  end

  reg txd_ff;
  reg nxt_txd;
  reg rx_ser_ff;
  reg nxt_rx_ser;
  reg tx_en_ff;
  reg nxt_tx_en;
  reg rx_en_ff;
  reg nxt_rx_en;

  // routing per test mode; idle line level is high
  always @* begin
    nxt_txd = tx_serial_i;
    nxt_rx_ser = rxd_sync_ff;
    nxt_tx_en = 1'b1;
    nxt_rx_en = 1'b1;
    case (chm_f)
      `UMM_CHM_NORMAL: begin
        nxt_txd = tx_serial_i;
        nxt_rx_ser = rxd_sync_ff;
      end
      `UMM_CHM_ECHO: begin
        nxt_txd = rxd_sync_ff;
        nxt_rx_ser = rxd_sync_ff;
      end
      `UMM_CHM_LOCAL: begin
        nxt_txd = 1'b1;
        nxt_rx_ser = tx_serial_i;
      end
      `UMM_CHM_REMOTE: begin
        nxt_txd = rxd_sync_ff;
        nxt_rx_ser = 1'b1;
        nxt_tx_en = 1'b0;
        nxt_rx_en = 1'b0;
      end
      default: begin
        nxt_txd = 1'b1;
        nxt_rx_ser = 1'b1;
      end
    endcase
  end

  // a retransmitted bit lags the pin by three cycles, far under a bit period
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txd_ff <= 1'b1;
      rx_ser_ff <= 1'b1;
      tx_en_ff <= 1'b0;
      rx_en_ff <= 1'b0;
    end else begin
      txd_ff <= nxt_txd;
      rx_ser_ff <= nxt_rx_ser;
      tx_en_ff <= nxt_tx_en;
      rx_en_ff <= nxt_rx_en;
    end
  end

  reg sck_out_ff;
  reg sck_oe_ff;

  // serial clock output from the internal baud clock
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sck_out_ff <= 1'b0;
      sck_oe_ff <= 1'b0;
    end else begin
      sck_out_ff <= baud_clk_i;
      sck_oe_ff <= ckdrv_f && !clks_f[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_o = rdata_ff;
  assign irq_o = irq_ff;
  assign rx_serial_o = rx_ser_ff;
  assign tx_enable_o = tx_en_ff;
  assign rx_enable_o = rx_en_ff;
  assign stop_halves_o = stop_halves_ff;
  assign stop_reserved_o = stop_rsvd_ff;
  assign char_bits_o = char_bits_ff;
  assign sync_mode_o = sync_ff;
  assign parity_type_o = par_ff;
  assign baud_source_select_o = clks_ff;
  assign sck_in_o = sck_sync_ff;
  assign txd_o = txd_ff;
  assign sck_o = sck_out_ff;
  assign sck_oe_o = sck_oe_ff;

endmodule

// ==== shared/umm_map.vh ====
// register map, field positions and reset values of the mode and interrupt-mask block
//
// Notes on behaviour
// - async stop field: 00 one, 01 one and half, 10 two, 11 reserved
// - sync stop field: 00 one, 10 two, 01 and 11 reserved
// - channel mode 00: plain receiver and transmitter, no loop paths
// - channel mode 01: receive input is routed onto the transmit pin
// - channel mode 10: transmitter output feeds the receiver input internally
// - channel mode 11: receive pin is wired straight to the transmit pin
// - nine-bit option 0 uses character-length field, 1 forces nine bits
// - serial clock pin driven only when clock-output select is 1 and source bit1 0
// - writing 1 to enable-set register enables that event, 0 does nothing
// - writing 1 to enable-clear register disables that event, 0 does nothing
// - mask register reads 1 for enabled events, 0 for disabled events
// - set, clear and mask registers share one ten-bit event layout
// - overrun, framing and parity errors are each separately maskable
// - interrupt output high whenever a status bit and its mask bit are set
// - local loopback ignores the receive pin and holds transmit pin high
// - remote loopback disables transmitter and receiver, transmit pin follows the receive pin
// - echo resends every received bit, transmitter programming has no effect
`ifndef UMM_MAP_VH
`define UMM_MAP_VH

// byte offsets
`define UMM_OFS_MODE 8'h04
`define UMM_OFS_IEN_SET 8'h08
`define UMM_OFS_IEN_CLR 8'h0C
`define UMM_OFS_IMASK 8'h10
`define UMM_OFS_EVT_STAT 8'h40

// mode register field positions
`define UMM_MODE_CLKS_LO 4
`define UMM_MODE_CHAR_LENGTH_FIELD_LO 6
`define UMM_MODE_SYNC 8
`define UMM_MODE_PAR_LO 9
`define UMM_MODE_STOP_LO 12
`define UMM_MODE_CHM_LO 14
`define UMM_MODE_NINE 17
`define UMM_MODE_CKDRV 18
// writable bits of the mode register
`define UMM_MODE_WMASK 32'h0006FFF0

// event bit positions
`define UMM_EV_RXRDY 0
`define UMM_EV_TXFREE 1
`define UMM_EV_BREAK 2
`define UMM_EV_RXEND 3
`define UMM_EV_TXEND 4
`define UMM_EV_OVERRUN 5
`define UMM_EV_FRAMING 6
`define UMM_EV_PARITY 7
`define UMM_EV_TIMEOUT 8
`define UMM_EV_DRAINED 9
`define UMM_EV_W 10

// channel modes
`define UMM_CHM_NORMAL 2'h0
`define UMM_CHM_ECHO 2'h1
`define UMM_CHM_LOCAL 2'h2
`define UMM_CHM_REMOTE 2'h3

// stop codes, results in half bit periods
`define UMM_STOP_ONE 2'h0
`define UMM_STOP_ONEHALF 2'h1
`define UMM_STOP_TWO 2'h2
`define UMM_HALVES_ONE 3'h2
`define UMM_HALVES_ONEHALF 3'h3
`define UMM_HALVES_TWO 3'h4

// reset values
`define UMM_RST_MODE 32'h00000000
`define UMM_RST_MASK 10'h000
`define UMM_RST_STAT 10'h000

`endif

// ==== verification/umm_core_checker.sv ====
// assertion checker for the mode decode, routing and interrupt mask ports
`timescale 1ns/10ps
module umm_core_checker (
  // clock and reset
  input logic sys_clk_i,
  input logic arst_n_i,
  // register port, events, interrupt
  input logic [7:0] reg_addr_i,
  input logic [31:0] reg_wdata_i,
  input logic reg_wr_i,
  input logic reg_rd_i,
  input logic [31:0] reg_rdata_o,
  input logic [9:0] event_i,
  input logic irq_o,
  // channel routing and decode
  input logic tx_serial_i,
  input logic rxd_i,
  input logic txd_o,
  input logic rx_serial_o,
  input logic tx_enable_o,
  input logic rx_enable_o,
  input logic [2:0] stop_halves_o,
  input logic [3:0] char_bits_o,
  input logic sck_oe_o
);
  logic [31:0] mode_ff;
  logic [9:0] mask_ff;
  logic [9:0] stat_ff;
  logic [1:0] up_ff;
  wire [1:0] chm = mode_ff[15:14];
  wire [1:0] sc = mode_ff[13:12];
  wire [2:0] hv = (sc == 2'h2) ? 3'h4 : (sc == 2'h1 && !mode_ff[8]) ? 3'h3 : 3'h2;
  wire [3:0] cb = mode_ff[17] ? 4'h9 : 4'h5 + {2'h0, mode_ff[7:6]};
  wire [9:0] clr = (reg_wr_i && reg_addr_i == 8'h40) ? reg_wdata_i[9:0] : 10'h000;

  // shadow state; up_ff keeps $past away from values seen during reset
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_ff <= 32'h0;
      mask_ff <= 10'h0;
      stat_ff <= 10'h0;
      up_ff <= 2'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == 8'h04) mode_ff <= reg_wdata_i & 32'h0006FFF0;
      if (reg_wr_i && reg_addr_i == 8'h08) mask_ff <= mask_ff | reg_wdata_i[9:0];
      if (reg_wr_i && reg_addr_i == 8'h0C) mask_ff <= mask_ff & ~reg_wdata_i[9:0];
      stat_ff <= (stat_ff & ~clr) | event_i;
      if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
    end
  end

  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_mask_rd;
    reg_rd_i && reg_addr_i == 8'h10;
  endsequence

  AST_STOP_LEN: assert property (up_ff != 2'h0 |-> stop_halves_o == $past(hv))
    else $error("stop length wrong");
  AST_CHAR_LEN: assert property (up_ff != 2'h0 |-> char_bits_o == $past(cb))
    else $error("char length wrong");
  AST_SCK_DRIVE: assert property (
    up_ff != 2'h0 |-> sck_oe_o == $past(mode_ff[18] && !mode_ff[5]))
    else $error("clock drive wrong");
  AST_NORMAL: assert property (
    up_ff != 2'h0 && $past(chm) == 2'h0 |-> txd_o == $past(tx_serial_i))
    else $error("normal path wrong");
  AST_LOCAL: assert property (
    up_ff != 2'h0 && $past(chm) == 2'h2 |-> txd_o && rx_serial_o == $past(tx_serial_i))
    else $error("local loop wrong");
  AST_ECHO: assert property (
    up_ff == 2'h3 && $past(chm[0]) |-> txd_o == $past(rxd_i, 3))
    else $error("echo path wrong");
  AST_REMOTE: assert property (
    up_ff != 2'h0 && $past(chm) == 2'h3 |-> !tx_enable_o && !rx_enable_o)
    else $error("remote enables wrong");
  AST_IRQ: assert property (up_ff != 2'h0 |-> irq_o == |(stat_ff & mask_ff))
    else $error("irq level wrong");
  AST_MASK_RD: assert property (
    s_mask_rd |=> reg_rdata_o == {22'h0, $past(mask_ff)})
    else $error("mask read wrong");
  // read data stands one cycle only, so a quiet cycle is followed by zero
  AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not idle");
endmodule

bind umm_core umm_core_checker chk_u (
  .sys_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .event_i, .irq_o, .tx_serial_i, .rxd_i, .txd_o, .rx_serial_o, .tx_enable_o,
  .rx_enable_o, .stop_halves_o, .char_bits_o, .sck_oe_o
);

// ==== verification/umm_line_partner.sv ====
// far-end serial transmitter driving the receive pin
`timescale 1ns/10ps
module umm_line_partner (
  // clock and reset
  input logic clk_i,
  input logic arst_n_i,
  // pace and pin
  input logic slow_i,
  output logic rxd_o,
  output logic rxd_d3_o
);
  logic [7:0] pat_ff;
  logic [2:0] hist_ff;
  logic hold_ff;

  // rotating pattern; slow pace holds each bit two clocks like a slower far end
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pat_ff <= 8'hB4;
      hist_ff <= 3'h7;
      hold_ff <= 1'h0;
    end else begin
      hold_ff <= ~hold_ff;
      if (!slow_i || hold_ff) pat_ff <= {pat_ff[6:0], pat_ff[7]};
      hist_ff <= {hist_ff[1:0], pat_ff[7]};
    end
  end
  assign rxd_o = pat_ff[7];
  assign rxd_d3_o = hist_ff[2];
endmodule

// ==== verification/tb_uart_mode_and_irq_mask.sv ====
// self-checking bench for the mode decode and interrupt mask block
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_uart_mode_and_irq_mask;
  logic sys_clk_i;
  logic arst_n_i = 1'h0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'h0;
  logic reg_rd_i = 1'h0;
  logic [9:0] event_i = 10'h0;
  logic tx_serial_i = 1'h0;
  logic baud_clk_i = 1'h0;
  logic slow = 1'h0;
  logic [31:0] reg_rdata_o;
  logic irq_o;
  logic rx_serial_o;
  logic tx_enable_o;
  logic rx_enable_o;
  logic [2:0] stop_halves_o;
  logic stop_reserved_o;
  logic [3:0] char_bits_o;
  logic rxd_i;
  logic txd_o;
  logic sck_oe_o;
  logic sync_mode_o;
  logic [2:0] parity_type_o;
  logic [1:0] baud_source_select_o;
  logic sck_in_o;
  logic sck_o;
  logic [9:0] dv;
  logic [5:0] fv;
  logic d3;
  logic [31:0] rv;
  logic [1:0] cm;
  logic [9:0] mk = 10'h0A1;
  int n_errors = 0;
  int tests_run = 0;
  // mode word, then {halves, reserved, char bits, clock drive, enables}
  // deliberate reserved codes
  logic [31:0] mw [14] = '{32'hFFF8000F, 32'h000010C0, 32'h00002040, 32'h00003080,
    32'h00001100, 32'h00002100, 32'h00003100, 32'h00020000, 32'h00040000, 32'h00040020,
    32'h00040010, 32'h00004000, 32'h00008000, 32'h0000C000};
  logic [9:0] ex [14] = '{10'h115, 10'h1A1, 10'h219, 10'h15D, 10'h155, 10'h215, 10'h155,
    10'h125, 10'h117, 10'h115, 10'h117, 10'h115, 10'h115, 10'h114};

  umm_core dut_u (.sys_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .event_i, .irq_o, .tx_serial_i, .baud_clk_i, .rx_serial_o, .tx_enable_o,
    .rx_enable_o, .stop_halves_o, .stop_reserved_o, .char_bits_o, .sync_mode_o,
    .parity_type_o, .baud_source_select_o, .sck_in_o, .rxd_i, .txd_o, .sck_i(tx_serial_i),
    .sck_o, .sck_oe_o);
  umm_line_partner line_u (.clk_i(sys_clk_i), .arst_n_i, .slow_i(slow), .rxd_o(rxd_i),
    .rxd_d3_o(d3));

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'h0;
    @(negedge sys_clk_i);
    d = reg_rdata_o;
  endtask
  task print_verdict;
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // toggling transmitter output so every routing path carries edges
  always @(posedge sys_clk_i) begin
    tx_serial_i <= ~tx_serial_i;
    baud_clk_i <= tx_serial_i;
  end
  initial begin
    sys_clk_i = 1'h0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    n_errors++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'h1;
    for (int i = 0; i < 14; i++) begin
      slow <= i[0];
      wr_reg(8'h04, mw[i]);
      rd_reg(8'h04, rv);
      `CHK("mode", mw[i] & 32'h0006FFF0, rv)
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      cm = mw[i][15:14];
      dv = {stop_halves_o, stop_reserved_o, char_bits_o, sck_oe_o, tx_enable_o & rx_enable_o};
      fv = {sync_mode_o, parity_type_o, baud_source_select_o};
      `CHK("decode", ex[i], dv)
      `CHK("fields", {mw[i][8], mw[i][11:9], mw[i][5:4]}, fv)
      // both clock paths toggle every cycle, so they line up with the transmitter toggle
      `CHK("sck", {2{tx_serial_i}}, {sck_o, sck_in_o})
      `CHK("txd", (cm == 2'h2) ? 1'h1 : cm[0] ? d3 : ~tx_serial_i, txd_o)
      `CHK("rxs", (cm == 2'h3) ? 1'h1 : (cm == 2'h2) ? ~tx_serial_i : d3, rx_serial_o)
    end
    // set and clear act only on ones; mask register ignores writes
    wr_reg(8'h08, 32'h0E0);
    wr_reg(8'h08, 32'h001);
    wr_reg(8'h0C, 32'h040);
    wr_reg(8'h10, 32'h3FF);
    rd_reg(8'h10, rv);
    `CHK("mask", 32'h0A1, rv)
    rd_reg(8'h08, rv);
    `CHK("set_rd", 32'h0, rv)
    rd_reg(8'h2C, rv);
    `CHK("unmapped", 32'h0, rv)
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk_i);
      event_i <= 10'h1 << i;
      @(posedge sys_clk_i);
      event_i <= 10'h0;
      @(negedge sys_clk_i);
      `CHK("irq_set", mk[i], irq_o)
      rd_reg(8'h40, rv);
      `CHK("stat", 32'h1 << i, rv)
      wr_reg(8'h40, 32'h1 << i);
      @(negedge sys_clk_i);
      `CHK("irq_clr", 1'h0, irq_o)
    end
    // mid-run reset lands while an unmasked event is pending
    @(posedge sys_clk_i);
    event_i <= 10'h001;
    @(posedge sys_clk_i);
    event_i <= 10'h000;
    arst_n_i <= 1'h0;
    @(negedge sys_clk_i);
    `CHK("rst_out", 4'h4, {irq_o, txd_o, tx_enable_o, sck_oe_o})
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'h1;
    rd_reg(8'h10, rv);
    `CHK("mask_rst", 32'h0, rv)
    rd_reg(8'h04, rv);
    `CHK("mode_rst", 32'h0, rv)
    print_verdict();
  end
endmodule
